// *** bench/tape_motion_command_decoder_test.sv ***
// Random and corner-case bench for the tape motion command decoder
module tape_motion_command_decoder_test;
  import tmd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ETK = 4;
  logic mclk, rst_b, clk_en, cmd_valid, write_gate, fault_clear, slow, diag_bad;
  tmd_cmd_t cmd;
  tmd_caps_t caps;
  tmd_deck_t deck;
  tmd_motion_t motion;
  logic command_complete, gap_found_line, invalid_cmd_fault, attention;
  logic run_rw, cur_stream;
  logic [31:0] seed, r;
  int n_mismatch, checks_done, ticks, i;

  tmd_decoder #(.ERASE_TICKS(ETK), .ERASE_CNT_W(16)) i_dut (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd(cmd), .caps(caps), .deck(deck), .write_gate(write_gate),
    .fault_clear(fault_clear), .motion(motion), .command_complete(command_complete),
    .gap_found_line(gap_found_line), .invalid_cmd_fault(invalid_cmd_fault), .attention(attention));
  tmd_deck_model i_deck (.mclk(mclk), .rst_b(rst_b), .motion(motion), .slow(slow), .diag_bad(diag_bad),
    .deck(deck));

  function automatic logic exp_bad(input tmd_cmd_t c, input tmd_caps_t k);
    logic [3:0] m;
    logic rw;
    m = c.modifier;
    rw = (m[MOD_REVERSE] && !k.reverse) || !(k.start_stop || k.streaming);
    case (c.op)
      OP_READ: exp_bad = rw;
      OP_WRITE: exp_bad = rw || (m[MOD_MARK] && !k.file_marks);
      OP_SPACE: exp_bad = (m[MOD_STREAM] && !k.file_marks) || (m[MOD_REVERSE] && !k.reverse);
      OP_POSITION: exp_bad = !k.position;
      OP_DIAG: exp_bad = !k.diagnostics;
      default: exp_bad = 1'b0;
    endcase
  endfunction : exp_bad

  function automatic tmd_kind_t kind_of(input logic [3:0] op);
    case (op)
      OP_READ: kind_of = MK_READ;
      OP_UNLOAD: kind_of = MK_UNLOAD;
      OP_DIAG: kind_of = MK_DIAG;
      OP_SPACE: kind_of = MK_SPACE;
      OP_POSITION: kind_of = MK_POSITION;
      OP_WRITE: kind_of = MK_WRITE;
      OP_ERASE: kind_of = MK_ERASE;
      default: kind_of = MK_NONE;
    endcase
  endfunction : kind_of

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic send(input tmd_cmd_t c, input logic clr);
    @(posedge mclk);
    #1;
    cmd = c;
    cmd_valid = !clr;
    fault_clear = clr;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    fault_clear = 1'b0;
  endtask : send

  task automatic wait_done(input logic need_none);
    int n;
    n = 0;
    while (n < 400 && !(command_complete === 1'b1 && (!need_none || motion.kind === MK_NONE))) begin
      @(posedge mclk);
      #1;
      n++;
      if (motion.kind === MK_ERASE && deck.len_tick) ticks++;
    end
    chk("finish", {7'h0, n < 400}, 8'h01);
  endtask : wait_done

  task automatic run(input tmd_cmd_t c, input logic chain);
    logic bad;
    logic seen;
    logic [3:0] m;
    int n;
    m = c.modifier;
    bad = exp_bad(c, caps);
    send(c, 1'b1);
    chk("cleared", {7'h0, invalid_cmd_fault}, 8'h00);
    ticks = 0;
    send(c, 1'b0);
    chk("fault", {7'h0, invalid_cmd_fault}, {7'h0, bad});
    chk("attention", {7'h0, attention}, {7'h0, bad});
    if (bad) begin
      chk("refused", {7'h0, command_complete}, 8'h01);
      return;
    end
    if (c.op == OP_HALT) begin
      seen = motion.stop;
      @(posedge mclk);
      #1;
      seen = seen | motion.stop;
      if (run_rw && cur_stream && !write_gate) chk("stop", {7'h0, seen}, 8'h01);
      run_rw = 1'b0;
      wait_done(1'b1);
      return;
    end
    run_rw = 1'b0;
    chk("kind", motion.kind, kind_of(c.op));
    chk("busy", {7'h0, command_complete}, 8'h00);
    if (c.op != OP_POSITION && c.op != OP_UNLOAD && c.op != OP_DIAG)
      chk("reverse", {7'h0, motion.reverse}, {7'h0, m[MOD_REVERSE]});
    if (c.op == OP_POSITION) chk("ew", {7'h0, motion.to_end_warning}, {7'h0, m[MOD_REVERSE]});
    if (c.op == OP_ERASE) chk("cont", {7'h0, motion.continuous}, {7'h0, m[1:0] == ERASE_CONTINUOUS});
    if (c.op == OP_SPACE) chk("fmark", {7'h0, motion.file_mark}, {7'h0, m[MOD_STREAM]});
    if (c.op == OP_WRITE) chk("fmark", {7'h0, motion.file_mark}, {7'h0, m[MOD_MARK]});
    if (c.op == OP_READ || c.op == OP_WRITE) begin
      cur_stream = (caps.start_stop && caps.streaming) ? m[MOD_STREAM] : caps.streaming;
      chk("stream", {7'h0, motion.streaming}, {7'h0, cur_stream});
      wait_done(1'b0);
      seen = 1'b0;
      repeat (12) begin
        @(posedge mclk);
        #1;
        seen = seen | (gap_found_line === 1'b1);
      end
      chk("gap", {7'h0, seen}, {7'h0, c.op == OP_WRITE || caps.internal_gap});
      chk("running", motion.kind, kind_of(c.op));
      run_rw = 1'b1;
      if (!chain) run({OP_HALT, 12'h000}, 1'b0);
      return;
    end
    wait_done(c.op == OP_SPACE);
    if (c.op == OP_DIAG) chk("diag", {7'h0, attention}, {7'h0, diag_bad});
    n = (m[1:0] + 1) * ETK;
    if (c.op == OP_ERASE && m[1:0] != ERASE_CONTINUOUS)
      chk("length", {7'h0, ticks >= n && ticks <= n + 3}, 8'h01);
  endtask : run

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    give_verdict;
  end

  initial begin
    seed = 32'h0000_01ab;
    {rst_b, cmd_valid, write_gate, fault_clear, slow, diag_bad, run_rw, cur_stream} = 8'h00;
    cmd = 16'h0000;
    caps = 7'h7f;
    clk_en = 1'b1;
    n_mismatch = 0;
    checks_done = 0;
    repeat (4) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    chk("rst kind", motion.kind, MK_NONE);
    chk("rst flags", {4'h0, command_complete, gap_found_line, invalid_cmd_fault, attention}, 8'h08);
    // A frozen enable must swallow a command pulse
    clk_en = 1'b0;
    send({OP_SPACE, 4'h0, 8'h00}, 1'b0);
    chk("frozen", motion.kind, MK_NONE);
    chk("frozen done", {7'h0, command_complete}, 8'h01);
    clk_en = 1'b1;
    // A running read is ended by a new motion command, not by itself
    run({OP_READ, 4'h8, 8'h00}, 1'b1);
    run({OP_SPACE, 4'h4, 8'h00}, 1'b0);
    run({OP_WRITE, 4'h2, 8'h00}, 1'b0);
    for (i = 0; i < 4; i++) run({OP_ERASE, 2'b01, i[1:0], 8'h00}, 1'b0);
    run({OP_POSITION, 4'h4, 8'h00}, 1'b0);
    run({OP_HALT, 4'h0, 8'h00}, 1'b0);
    caps = 7'h00;
    run({OP_READ, 4'h4, 8'h00}, 1'b0);
    run({OP_DIAG, 4'h0, 8'h00}, 1'b0);
    $display("corner tests done");
    for (i = 0; i < 60; i++) begin
      r = $random(seed);
      caps = r[6:0];
      {slow, diag_bad, write_gate} = r[9:7];
      run({4'h6 + {1'b0, r[12:10]}, r[16:13], r[31:24]}, 1'b0);
      $display("random test %0d done", i);
    end
    give_verdict;
  end
endmodule : tape_motion_command_decoder_test

// *** bench/tmd_deck_model.sv ***
// Behavioural deck answering the decoder's motion requests
module tmd_deck_model
  import tmd_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Request and knobs
  input wire tmd_motion_t motion,
  input wire logic slow,
  input wire logic diag_bad,
  // Deck events
  output tmd_deck_t deck
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt;
  logic [7:0] lag;
  tmd_kind_t kind_q;
  logic stop_q;
  logic go;
  assign lag = slow ? 8'h06 : 8'h02;
  // Events wait a cycle so a count left from the last motion cannot leak
  assign go = motion.kind != MK_NONE && motion.kind == kind_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 8'h00;
      kind_q <= MK_NONE;
      stop_q <= 1'b0;
    end else begin
      kind_q <= motion.kind;
      stop_q <= motion.stop && go;
      // Saturate so a long read cannot wrap back to the spin-up phase
      if (motion.kind != kind_q) cnt <= 8'h00;
      else if (cnt != 8'hff) cnt <= cnt + 8'h01;
    end
  end
  always_comb begin
    deck = '0;
    deck.at_speed = go && cnt >= lag;
    deck.gap_detect = deck.at_speed && cnt[2:0] == 3'h5;
    deck.gap_written = deck.at_speed && motion.kind == MK_WRITE;
    deck.stopped = stop_q;
    deck.mark_reached = go && (motion.kind == MK_POSITION || (motion.kind == MK_SPACE && motion.file_mark)) &&
                        cnt >= lag + 8'h04;
    deck.tape_limit = go && motion.kind == MK_ERASE && motion.continuous && cnt >= lag + 8'h0c;
    deck.op_done = go && (motion.kind == MK_UNLOAD || motion.kind == MK_DIAG) && cnt >= lag + 8'h04;
    deck.diag_fault = diag_bad && motion.kind == MK_DIAG;
    deck.len_tick = go && motion.kind == MK_ERASE && !motion.stop && cnt[0];
  end
endmodule : tmd_deck_model

// *** verilog/tmd_decoder.sv ***
// Tape motion command decoder and sequencer
// Function
// - Modifier bits 11-8 are interpreted according to the received opcode.
// - Opcode 0110 starts a read at the present tape position.
// - With internal gap detection, gap line rises as soon as gap seen.
// - Read completes once started, at speed and gap line valid.
// - Read or write runs until halt or another motion command.
// - Read bit 11 selects streaming; ignored on single-mode drives.
// - Read bit 10 selects reverse; unsupported reverse is invalid.
// - Opcode 0111 rewinds and unloads, then completes.
// - Opcode 1000 runs diagnostics; attention with completion marks a fault.
// - Opcode 1001 spaces to next gap, completes once stopped in it.
// - Space bit 11 goes to next file mark; invalid without file marks.
// - Space bit 10 selects reverse; invalid if reverse unsupported.
// - Opcode 1010 goes to end warning or start mark, then completes.
// - Opcode 1011 writes; gap line rises at speed with gap written.
// - Write completes at speed once gap line valid.
// - Write bit 11 streaming, bit 10 reverse; unsupported reverse invalid.
// - Write bit 9 records file mark and gap first; invalid if unsupported.
// - Opcode 1100 erases a fixed length from present position.
// - Erase bit 10 reverses; bits 9-8 give one, two, three lengths.
// - Continuous erase stops at tape end or begin, then completes.
// - Continuous erase takes precedence over a fixed length.
// - Every erase length code is accepted without error.
// - Any invalid command sets fault status bit 5 and raises attention.
// - Halt stops at next gap in start/stop, at once in streaming with the write gate closed.
module tmd_decoder
  import tmd_pkg::*;
#(
  parameter int ERASE_TICKS = ERASE_BASE_TICKS,
  parameter int ERASE_CNT_W = 16
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Received command word
  input wire logic cmd_valid,
  input wire tmd_cmd_t cmd,
  // Drive capabilities
  input wire tmd_caps_t caps,
  // Deck events
  input wire tmd_deck_t deck,
  input wire logic write_gate,
  // Deck control reset of attention and faults
  input wire logic fault_clear,
  // Motion request
  output tmd_motion_t motion,
  // Indications to the controller
  output logic command_complete,
  output logic gap_found_line,
  output logic invalid_cmd_fault,
  output logic attention
);
  tmd_state_t state;
  tmd_kind_t d_kind;
  logic d_rev;
  logic d_stream;
  logic d_mark;
  logic d_ew;
  logic d_cont;
  logic d_bad;
  logic one_mode;
  logic is_halt;
  logic accept;
  logic start_motion;
  logic halt_now;
  logic erase_done;
  logic seek_hit;

  if (ERASE_TICKS < 1) begin : g_check
    $error("tmd_decoder: ERASE_TICKS must be at least one");
  end

  assign accept = clk_en && cmd_valid;
  assign is_halt = cmd.op == OP_HALT;
  assign one_mode = caps.streaming ^ caps.start_stop;
  assign start_motion = accept && d_kind != MK_NONE && !d_bad;

  // Decode of opcode and modifier
  always_comb begin
    d_kind = MK_NONE;
    d_rev = cmd.modifier[MOD_REVERSE];
    d_stream = one_mode ? caps.streaming : cmd.modifier[MOD_STREAM];
    d_mark = 1'b0;
    d_ew = 1'b0;
    d_cont = 1'b0;
    d_bad = 1'b0;
    unique case (cmd.op)
      OP_READ: begin
        d_kind = MK_READ;
        d_bad = (!caps.streaming && !caps.start_stop) || (d_rev && !caps.reverse);
      end
      OP_UNLOAD: begin
        d_kind = MK_UNLOAD;
        d_rev = 1'b0;
      end
      OP_DIAG: begin
        d_kind = MK_DIAG;
        d_rev = 1'b0;
        d_bad = !caps.diagnostics;
      end
      OP_SPACE: begin
        d_kind = MK_SPACE;
        d_mark = cmd.modifier[MOD_STREAM];
        d_bad = (d_mark && !caps.file_marks) || (d_rev && !caps.reverse);
      end
      OP_POSITION: begin
        d_kind = MK_POSITION;
        d_ew = cmd.modifier[MOD_REVERSE];
        d_rev = 1'b0;
        d_bad = !caps.position;
      end
      OP_WRITE: begin
        d_kind = MK_WRITE;
        d_mark = cmd.modifier[MOD_MARK];
        d_bad = (!caps.streaming && !caps.start_stop) || (d_rev && !caps.reverse) ||
                (d_mark && !caps.file_marks);
      end
      OP_ERASE: begin
        d_kind = MK_ERASE;
        d_cont = cmd.modifier[MOD_MARK:ERASE_LEN_LSB] == ERASE_CONTINUOUS;
        d_stream = 1'b0;
        d_bad = 1'b0;
      end
      default: begin
        d_rev = 1'b0;
      end
    endcase
  end

  // Streaming halt with the write gate closed stops at once
  assign halt_now = motion.streaming && !write_gate;

  // What ends the positioning phase of space, position and erase; unload and diagnostics end on op_done
  always_comb begin
    seek_hit = 1'b0;
    unique case (motion.kind)
      MK_SPACE: seek_hit = motion.file_mark ? deck.mark_reached : deck.gap_detect;
      MK_POSITION: seek_hit = deck.mark_reached;
      MK_ERASE: seek_hit = motion.continuous ? deck.tape_limit : erase_done;
      default: seek_hit = 1'b0;
    endcase
  end

  tmd_erase_meter #(
    .BASE_TICKS(ERASE_TICKS),
    .CNT_W(ERASE_CNT_W)
  ) u_meter (
    .mclk(mclk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .start(start_motion && d_kind == MK_ERASE),
    .mult(cmd.modifier[MOD_MARK:ERASE_LEN_LSB]),
    .tick(deck.len_tick),
    .done(erase_done)
  );

  // Sequencer state and motion request
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      motion <= '{kind: MK_NONE, default: 1'b0};
    end else if (clk_en) begin
      if (start_motion) begin
        // A new motion command ends any read or write in progress
        motion <= '{kind: d_kind, reverse: d_rev, streaming: d_stream, file_mark: d_mark,
                    to_end_warning: d_ew, continuous: d_cont, stop: 1'b0};
        state <= (d_kind == MK_READ || d_kind == MK_WRITE) ? ST_RAMP : ST_SEEK;
      end else if (accept && is_halt && state != ST_IDLE && state != ST_STOP) begin
        if (state == ST_SEEK || halt_now) begin
          motion.stop <= 1'b1;
          state <= ST_STOP;
        end else begin
          state <= ST_HALT;
        end
      end else begin
        unique case (state)
          ST_IDLE: state <= ST_IDLE;
          ST_RAMP: begin
            if (deck.at_speed && (motion.kind == MK_READ || deck.gap_written)) begin
              state <= ST_RUN;
            end
          end
          ST_RUN: state <= ST_RUN;
          ST_SEEK: begin
            if ((motion.kind == MK_UNLOAD || motion.kind == MK_DIAG) && deck.op_done) begin
              state <= ST_IDLE;
              motion <= '{kind: MK_NONE, default: 1'b0};
            end else if (seek_hit) begin
              motion.stop <= 1'b1;
              state <= ST_STOP;
            end
          end
          ST_HALT: begin
            if (deck.gap_detect) begin
              motion.stop <= 1'b1;
              state <= ST_STOP;
            end
          end
          ST_STOP: begin
            if (deck.stopped) begin
              state <= ST_IDLE;
              motion <= '{kind: MK_NONE, default: 1'b0};
            end
          end
        endcase
      end
    end
  end

  // Command complete: dropped on a new command, raised when it finishes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      command_complete <= COMPLETE_RESET;
    end else if (clk_en) begin
      if (accept && (is_halt || d_kind != MK_NONE)) begin
        // Invalid requests complete at once so the host can read status
        command_complete <= d_bad || (is_halt && (state == ST_IDLE || state == ST_STOP));
      end else if (state == ST_RAMP && deck.at_speed && (motion.kind == MK_READ || deck.gap_written)) begin
        command_complete <= 1'b1;
      end else if (state == ST_SEEK && (motion.kind == MK_UNLOAD || motion.kind == MK_DIAG) && deck.op_done) begin
        command_complete <= 1'b1;
      end else if (state == ST_STOP && deck.stopped) begin
        command_complete <= 1'b1;
      end
    end
  end

  // Gap found line: read follows the deck detector, write the written gap
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gap_found_line <= FLAG_RESET;
    end else if (clk_en) begin
      if (state != ST_RAMP && state != ST_RUN && state != ST_HALT) begin
        gap_found_line <= 1'b0;
      end else if (motion.kind == MK_READ) begin
        gap_found_line <= caps.internal_gap && deck.at_speed && deck.gap_detect;
      end else begin
        gap_found_line <= deck.at_speed && deck.gap_written;
      end
    end
  end

  // Fault and attention; a new fault wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      invalid_cmd_fault <= FLAG_RESET;
      attention <= FLAG_RESET;
    end else if (clk_en) begin
      invalid_cmd_fault <= (accept && d_kind != MK_NONE && d_bad) || (invalid_cmd_fault && !fault_clear);
      attention <= (accept && d_kind != MK_NONE && d_bad) ||
                   (state == ST_SEEK && motion.kind == MK_DIAG && deck.op_done && deck.diag_fault) ||
                   (attention && !fault_clear);
    end
  end

  AST_OPCODE_FIELD: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && cmd.op == OP_READ && !d_bad |=> motion.kind == MK_READ && state == ST_RAMP)
    else $error("read opcode not decoded from top bits");

  AST_READ_REVERSE: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && cmd.op == OP_READ && cmd.modifier[MOD_REVERSE] && !caps.reverse
    |=> invalid_cmd_fault && attention && (motion.kind != MK_READ || $past(motion.kind) == MK_READ))
    else $error("unsupported reverse read not reported");

  AST_FAULT_ATTN: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(invalid_cmd_fault) |-> attention && command_complete)
    else $error("invalid command fault without attention");

  AST_RW_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    state == ST_RUN && !cmd_valid |=> state == ST_RUN && motion.kind == $past(motion.kind))
    else $error("read or write ended without a command");

  AST_READ_COMPLETE: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(command_complete) && motion.kind == MK_READ |-> $past(deck.at_speed) && state == ST_RUN)
    else $error("read completed before reaching speed");

  AST_WRITE_GAP: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && state == ST_RAMP && motion.kind == MK_WRITE && deck.at_speed && deck.gap_written && !cmd_valid
    |=> gap_found_line && command_complete)
    else $error("write gap or completion missing at speed");

  AST_SPACE_STOP: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && state == ST_SEEK && motion.kind == MK_SPACE && !motion.file_mark && deck.gap_detect && !cmd_valid
    |=> state == ST_STOP && motion.stop && !command_complete)
    else $error("space did not stop at the gap");

  AST_CONT_ERASE: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && state == ST_SEEK && motion.kind == MK_ERASE && motion.continuous && deck.tape_limit && !cmd_valid
    |=> state == ST_STOP && motion.stop && !command_complete)
    else $error("continuous erase ignored tape limit");

  AST_ERASE_NOERR: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && cmd.op == OP_ERASE && !invalid_cmd_fault |=> !invalid_cmd_fault && motion.kind == MK_ERASE)
    else $error("erase length code reported invalid");

  AST_HALT_STREAM: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && is_halt && state == ST_RUN && motion.streaming && !write_gate |=> state == ST_STOP && motion.stop)
    else $error("streaming halt did not stop at once");

  AST_STOP_DONE: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && state == ST_STOP && deck.stopped && !cmd_valid
    |=> command_complete && state == ST_IDLE && motion.kind == MK_NONE)
    else $error("stopped tape did not complete");

  AST_SPACE_REVERSE: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && cmd.op == OP_SPACE && cmd.modifier[MOD_REVERSE] && !caps.reverse
    |=> invalid_cmd_fault && attention && command_complete)
    else $error("unsupported reverse space not reported");

  AST_SPACE_MARK: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && cmd.op == OP_SPACE && cmd.modifier[MOD_STREAM] && !caps.file_marks
    |=> invalid_cmd_fault && attention && command_complete)
    else $error("space to file mark without support not reported");

  AST_WRITE_REVERSE: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && cmd.op == OP_WRITE && cmd.modifier[MOD_REVERSE] && !caps.reverse
    |=> invalid_cmd_fault && attention && command_complete)
    else $error("unsupported reverse write not reported");

  AST_WRITE_MARK: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && cmd.op == OP_WRITE && cmd.modifier[MOD_MARK] && !caps.file_marks
    |=> invalid_cmd_fault && attention && command_complete)
    else $error("file mark write without support not reported");

  AST_READ_GAP: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && state == ST_RUN && motion.kind == MK_READ && caps.internal_gap
    && deck.at_speed && deck.gap_detect && !cmd_valid |=> gap_found_line)
    else $error("read gap not shown on the gap line");

  AST_ERASE_CONT: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && cmd.op == OP_ERASE && cmd.modifier[MOD_MARK:ERASE_LEN_LSB] == ERASE_CONTINUOUS
    |=> motion.kind == MK_ERASE && motion.continuous)
    else $error("erase code 11 not taken as continuous");

  AST_DIAG_FAULT: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && state == ST_SEEK && motion.kind == MK_DIAG && deck.op_done && deck.diag_fault && !cmd_valid
    |=> command_complete && attention)
    else $error("diagnostic fault not flagged with completion");

  AST_HALT_GAP: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && state == ST_HALT && deck.gap_detect && !cmd_valid |=> state == ST_STOP && motion.stop)
    else $error("start/stop halt did not stop at the gap");

  AST_FAULT_CLEAR: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && fault_clear && !cmd_valid |=> !invalid_cmd_fault)
    else $error("fault status survived a clear");

  AST_POSITION_DIR: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && cmd.op == OP_POSITION && caps.position
    |=> motion.kind == MK_POSITION && motion.to_end_warning == $past(cmd.modifier[MOD_REVERSE]))
    else $error("position target not taken from bit 10");
endmodule : tmd_decoder

// *** verilog/tmd_erase_meter.sv ***
// Measures a fixed erase length as a multiple of the base length
module tmd_erase_meter
  import tmd_pkg::*;
#(
  parameter int BASE_TICKS = ERASE_BASE_TICKS,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Control
  input wire logic start,
  input wire logic [1:0] mult,
  input wire logic tick,
  // Result
  output logic done
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] target;
  logic running;

  if (BASE_TICKS < 1 || 3 * BASE_TICKS >= (1 << CNT_W)) begin : g_check
    $error("tmd_erase_meter: BASE_TICKS does not fit CNT_W");
  end

  // Code 00 is one base length, 01 two, 10 three
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      target <= '0;
    end else if (clk_en && start) begin
      target <= CNT_W'(BASE_TICKS * (int'(mult) + 1));
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        count <= '0;
        running <= 1'b1;
        done <= 1'b0;
      end else if (running && count == target) begin
        running <= 1'b0;
        done <= 1'b1;
      end else if (running && tick) begin
        count <= count + CNT_W'(1);
      end
    end
  end
endmodule : tmd_erase_meter

// *** verilog/tmd_pkg.sv ***
// Types and constants shared by the tape motion command decoder
package tmd_pkg;
  // Opcodes of the tape motion commands
  localparam logic [3:0] OP_READ = 4'h6;
  localparam logic [3:0] OP_UNLOAD = 4'h7;
  localparam logic [3:0] OP_DIAG = 4'h8;
  localparam logic [3:0] OP_SPACE = 4'h9;
  localparam logic [3:0] OP_POSITION = 4'hA;
  localparam logic [3:0] OP_WRITE = 4'hB;
  localparam logic [3:0] OP_ERASE = 4'hC;
  localparam logic [3:0] OP_HALT = 4'hD;

  // Bit positions inside the four-bit modifier (word bits 11, 10, 9, 8)
  localparam int MOD_STREAM = 3;
  localparam int MOD_REVERSE = 2;
  localparam int MOD_MARK = 1;
  localparam int ERASE_LEN_LSB = 0;
  localparam logic [1:0] ERASE_CONTINUOUS = 2'h3;

  // Base erase length, in length ticks reported by the deck
  localparam int ERASE_BASE_TICKS = 1024;

  // Reset values of the outputs
  localparam logic COMPLETE_RESET = 1'b1;
  localparam logic FLAG_RESET = 1'b0;

  typedef enum logic [7:0] {
    MK_NONE = 8'h01,
    MK_READ = 8'h02,
    MK_WRITE = 8'h04,
    MK_UNLOAD = 8'h08,
    MK_DIAG = 8'h10,
    MK_SPACE = 8'h20,
    MK_POSITION = 8'h40,
    MK_ERASE = 8'h80
  } tmd_kind_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RAMP = 6'h02,
    ST_RUN = 6'h04,
    ST_SEEK = 6'h08,
    ST_HALT = 6'h10,
    ST_STOP = 6'h20
  } tmd_state_t;

  // Received command word: opcode on top, modifier below it
  typedef struct packed {
    logic [3:0] op;
    logic [3:0] modifier;
    logic [7:0] arg;
  } tmd_cmd_t;

  // What this drive supports
  typedef struct packed {
    logic start_stop;
    logic streaming;
    logic reverse;
    logic file_marks;
    logic position;
    logic internal_gap;
    logic diagnostics;
  } tmd_caps_t;

  // Events reported by the deck mechanics
  typedef struct packed {
    logic at_speed;
    logic gap_detect;
    logic gap_written;
    logic stopped;
    logic mark_reached;
    logic tape_limit;
    logic op_done;
    logic diag_fault;
    logic len_tick;
  } tmd_deck_t;

  // Motion request handed to the deck
  typedef struct packed {
    tmd_kind_t kind;
    logic reverse;
    logic streaming;
    logic file_mark;
    logic to_end_warning;
    logic continuous;
    logic stop;
  } tmd_motion_t;
endpackage : tmd_pkg
